// *** verilog/ea_gen_pkg.sv ***
// Package: addressing modes, opcode fields and carriers for the address generator
package ea_gen_pkg;

    // Addressing modes handled by the generator
    typedef enum logic [2:0] {
        MODE_EXT = 3'b000,
        MODE_IX  = 3'b001,
        MODE_IX1 = 3'b010,
        MODE_IX2 = 3'b011,
        MODE_REL = 3'b100,
        MODE_BSC = 3'b101,
        MODE_BTB = 3'b110
    } addr_mode_t;

    // Program counter advance per mode
    localparam logic [15:0] ADV_EXT = 16'h0003;
    localparam logic [15:0] ADV_IX  = 16'h0001;
    localparam logic [15:0] ADV_IX1 = 16'h0002;
    localparam logic [15:0] ADV_IX2 = 16'h0003;
    localparam logic [15:0] ADV_REL = 16'h0002;
    localparam logic [15:0] ADV_BSC = 16'h0002;
    localparam logic [15:0] ADV_BTB = 16'h0003;

    // Opcode field positions for bit instructions
    localparam int BITNUM_LSB = 1;
    localparam int BITNUM_MSB = 3;
    localparam int BITSEL_POS = 0;

    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // One decode request
    typedef struct packed {
        addr_mode_t mode;
        logic [7:0] opcode;
        logic [7:0] operand1;
        logic [7:0] operand2;
        logic [7:0] index;
        logic [15:0] pc;
        logic branch_cond;
        logic [7:0] tested_byte;
    } ea_req_t;

    // One decode result
    typedef struct packed {
        logic [7:0] addr_high;
        logic [7:0] addr_low;
        logic [15:0] next_pc;
        logic [7:0] tested_byte_pointer;
        logic [15:0] bit_branch_target;
        logic [2:0] bit_number;
        logic bit_select;
        logic carry_write;
        logic carry_value;
        logic branch_taken;
    } ea_resp_t;

endpackage

// *** verilog/effective_address_generator.sv ***
// Effective address, next program counter and branch target generator
module effective_address_generator
    import ea_gen_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Request: one decode per valid cycle
    input wire logic req_valid,
    input wire ea_req_t req,
    // Result, registered one cycle after the request
    output logic resp_valid,
    output ea_resp_t resp
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] sext8(input logic [7:0] b);
        sext8 = {{8{b[7]}}, b};
    endfunction

    // Offset is relative to the address after the instruction, which fixes
    // the reach quoted for each branch form
    function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                               input logic [15:0] len,
                                               input logic [7:0] off);
        rel_target = pc + len + sext8(off);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Combinational decode

    ea_resp_t resp_nxt;
    logic [8:0] sum9;
    logic [2:0] bitn;
    logic bitsel;
    logic tested;

    always_comb begin
        sum9 = 9'h000;
        bitn = req.opcode[BITNUM_MSB:BITNUM_LSB];
        bitsel = req.opcode[BITSEL_POS];
        tested = req.tested_byte[bitn];
        resp_nxt = '0;
        resp_nxt.bit_number = bitn;
        resp_nxt.bit_select = bitsel;
        resp_nxt.next_pc = req.pc;
        unique case (req.mode)
            MODE_EXT: begin
                resp_nxt.addr_high = req.operand1;
                resp_nxt.addr_low = req.operand2;
                resp_nxt.next_pc = req.pc + ADV_EXT;
            end
            MODE_IX: begin
                resp_nxt.addr_high = PAGE_ZERO;
                resp_nxt.addr_low = req.index;
                resp_nxt.next_pc = req.pc + ADV_IX;
            end
            MODE_IX1: begin
                sum9 = {1'b0, req.index} + {1'b0, req.operand1};
                resp_nxt.addr_high = {7'h00, sum9[8]};
                resp_nxt.addr_low = sum9[7:0];
                resp_nxt.next_pc = req.pc + ADV_IX1;
            end
            MODE_IX2: begin
                sum9 = {1'b0, req.index} + {1'b0, req.operand2};
                resp_nxt.addr_low = sum9[7:0];
                resp_nxt.addr_high = req.operand1 + {7'h00, sum9[8]};
                resp_nxt.next_pc = req.pc + ADV_IX2;
            end
            MODE_REL: begin
                resp_nxt.branch_taken = req.branch_cond;
                if (req.branch_cond) begin
                    resp_nxt.next_pc =
                        rel_target(req.pc, ADV_REL, req.operand1);
                end else begin
                    resp_nxt.next_pc = req.pc + ADV_REL;
                end
                resp_nxt.addr_high = resp_nxt.next_pc[15:8];
                resp_nxt.addr_low = resp_nxt.next_pc[7:0];
            end
            MODE_BSC: begin
                resp_nxt.addr_high = PAGE_ZERO;
                resp_nxt.addr_low = req.operand1;
                resp_nxt.next_pc = req.pc + ADV_BSC;
            end
            MODE_BTB: begin
                resp_nxt.tested_byte_pointer = req.operand1;
                resp_nxt.addr_high = PAGE_ZERO;
                resp_nxt.addr_low = req.operand1;
                resp_nxt.bit_branch_target =
                    rel_target(req.pc, ADV_BTB, req.operand2);
                resp_nxt.carry_write = 1'b1;
                resp_nxt.carry_value = tested;
                // Selector low branches on set, high on clear
                resp_nxt.branch_taken = (tested == ~bitsel);
                resp_nxt.next_pc = resp_nxt.branch_taken ?
                    resp_nxt.bit_branch_target :
                    req.pc + ADV_BTB;
            end
            default: begin
                // Unused mode code: hold the PC, no side effects
                resp_nxt.next_pc = req.pc;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers
    //
    // Each concern keeps its own register, so a change to one field (say,
    // a wider carry path) does not disturb the others. All but resp_valid load
    // together on an accepted request and otherwise hold, so the caller
    // may read a result for as long as it likes.

    logic [7:0] addr_high_r;
    logic [7:0] addr_low_r;
    logic [15:0] next_pc_r;
    logic [7:0] pointer_r;
    logic [15:0] target_r;
    logic [2:0] bit_number_r;
    logic bit_select_r;
    logic carry_write_r;
    logic carry_value_r;
    logic branch_taken_r;

    // Valid follows the request by exactly one cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= req_valid;
        end
    end

    // Address bus halves
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            addr_high_r <= 8'h00;
            addr_low_r <= 8'h00;
        end else if (req_valid) begin
            addr_high_r <= resp_nxt.addr_high;
            addr_low_r <= resp_nxt.addr_low;
        end
    end

    // Program counter advance or branch target
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            next_pc_r <= PC_RESET;
        end else if (req_valid) begin
            next_pc_r <= resp_nxt.next_pc;
        end
    end

    // Bit test pointer and its branch target
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pointer_r <= 8'h00;
            target_r <= 16'h0000;
        end else if (req_valid) begin
            pointer_r <= resp_nxt.tested_byte_pointer;
            target_r <= resp_nxt.bit_branch_target;
        end
    end

    // Bit number and selector decoded from the opcode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_number_r <= 3'h0;
            bit_select_r <= 1'b0;
        end else if (req_valid) begin
            bit_number_r <= resp_nxt.bit_number;
            bit_select_r <= resp_nxt.bit_select;
        end
    end

    // Carry update; the core applies it only while carry_write is high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            carry_write_r <= 1'b0;
            carry_value_r <= 1'b0;
        end else if (req_valid) begin
            carry_write_r <= resp_nxt.carry_write;
            carry_value_r <= resp_nxt.carry_value;
        end
    end

    // Branch decision of the last request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            branch_taken_r <= 1'b0;
        end else if (req_valid) begin
            branch_taken_r <= resp_nxt.branch_taken;
        end
    end

    // Gather the registers into the result carrier
    always_comb begin
        resp.addr_high = addr_high_r;
        resp.addr_low = addr_low_r;
        resp.next_pc = next_pc_r;
        resp.tested_byte_pointer = pointer_r;
        resp.bit_branch_target = target_r;
        resp.bit_number = bit_number_r;
        resp.bit_select = bit_select_r;
        resp.carry_write = carry_write_r;
        resp.carry_value = carry_value_r;
        resp.branch_taken = branch_taken_r;
    end

endmodule

// *** dv/ea_gen_props.sv ***
// Checker: address, next PC and carry relations of the address generator
module ea_gen_props
    import ea_gen_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Request and result
    input wire logic req_valid,
    input wire ea_req_t req,
    input wire logic resp_valid,
    input wire ea_resp_t resp
);
    ea_req_t p_r;
    // Copy of the request, so results can be tied to their cause
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) p_r <= '0;
        else p_r <= req;
    end
    function automatic logic v(addr_mode_t m);
        return req_valid && req.mode == m;
    endfunction
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    valid_latency_a: assert property (resp_valid == $past(req_valid))
        else $error("result valid not one cycle after request");
    ext_addr_a: assert property (v(MODE_EXT) |=> resp.next_pc == p_r.pc +
        ADV_EXT && {resp.addr_high, resp.addr_low} == {p_r.operand1,
        p_r.operand2}) else $error("extended address wrong");
    ix_addr_a: assert property (v(MODE_IX) |=> resp.addr_high == PAGE_ZERO &&
        resp.addr_low == p_r.index && resp.next_pc == p_r.pc + ADV_IX)
        else $error("indexed address wrong");
    ix_short_a: assert property (v(MODE_IX1) |=> {resp.addr_high,
        resp.addr_low} == 16'(p_r.index) + 16'(p_r.operand1))
        else $error("short offset address wrong");
    ix_long_a: assert property (v(MODE_IX2) |=> {resp.addr_high,
        resp.addr_low} == {p_r.operand1, p_r.operand2} + 16'(p_r.index))
        else $error("long offset address wrong");
    rel_target_a: assert property (v(MODE_REL) |=> resp.next_pc ==
        p_r.pc + ADV_REL + (p_r.branch_cond ? {{8{p_r.operand1[7]}},
        p_r.operand1} : 16'h0000)) else $error("relative target wrong");
    bit_field_a: assert property (v(MODE_BSC) |=> resp.addr_low ==
        p_r.operand1 && resp.addr_high == PAGE_ZERO && resp.bit_number ==
        p_r.opcode[3:1] && resp.bit_select == p_r.opcode[0])
        else $error("bit set clear decode wrong");
    btb_target_a: assert property (v(MODE_BTB) |=> resp.addr_low ==
        p_r.operand1 && resp.bit_branch_target == p_r.pc + ADV_BTB +
        {{8{p_r.operand2[7]}}, p_r.operand2}) else $error("bit branch wrong");
    btb_carry_a: assert property (v(MODE_BTB) |=> resp.carry_write &&
        resp.carry_value == p_r.tested_byte[p_r.opcode[3:1]])
        else $error("tested bit not copied to carry");
    cover property (v(MODE_BTB) ##1 resp.branch_taken);
    cover property (v(MODE_REL) ##1 resp.branch_taken);
    cover property (req_valid [*3]);
endmodule

bind effective_address_generator ea_gen_props i_props (.clock(clock),
    .resetn(resetn), .req_valid(req_valid), .req(req),
    .resp_valid(resp_valid), .resp(resp));

// *** dv/effective_address_generator_tb.sv ***
// Testbench: random requests in all modes against a reference model
module effective_address_generator_tb;
    import ea_gen_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, resetn = 0, req_valid = 0, pv = 0;
    ea_req_t req = '0;
    logic resp_valid;
    ea_resp_t resp;
    ea_resp_t exp_r = '0;
    int errors = 0, n_tests = 0;
    effective_address_generator i_effective_address_generator (
        .clock(clock), .resetn(resetn), .req_valid(req_valid),
        .req(req), .resp_valid(resp_valid), .resp(resp));
    initial forever #2.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    function automatic ea_resp_t model(ea_req_t r);
        ea_resp_t e;
        int pc, ea, np, t;
        e = '0;
        pc = r.pc;
        ea = 0;
        np = pc;
        t = r.tested_byte[r.opcode[3:1]];
        e.bit_number = r.opcode[3:1];
        e.bit_select = r.opcode[0];
        case (r.mode)
            MODE_EXT: begin
                ea = r.operand1 * 256 + r.operand2;
                np = pc + 3;
            end
            MODE_IX: begin
                ea = r.index;
                np = pc + 1;
            end
            MODE_IX1: begin
                ea = r.index + r.operand1;
                np = pc + 2;
            end
            MODE_IX2: begin
                ea = r.operand1 * 256 + r.operand2 + r.index;
                np = pc + 3;
            end
            MODE_REL: begin
                e.branch_taken = r.branch_cond;
                np = pc + 2 + (r.branch_cond ? $signed(r.operand1) : 0);
                ea = np;
            end
            MODE_BSC: begin
                ea = r.operand1;
                np = pc + 2;
            end
            MODE_BTB: begin
                ea = r.operand1;
                e.tested_byte_pointer = r.operand1;
                e.bit_branch_target = 16'(pc + 3 + $signed(r.operand2));
                e.carry_write = 1'b1;
                e.carry_value = t[0];
                // Selector low branches on a set bit, high on a clear one
                e.branch_taken = t[0] != r.opcode[0];
                np = pc + 3 + (e.branch_taken ? $signed(r.operand2) : 0);
            end
            default: begin
                np = pc;
            end
        endcase
        {e.addr_high, e.addr_low} = 16'(ea);
        e.next_pc = 16'(np);
        return e;
    endfunction
    task automatic step();
        @(negedge clock);
        chk(resp_valid, pv);
        if (pv) begin
            chk(resp.addr_high, exp_r.addr_high);
            chk(resp.addr_low, exp_r.addr_low);
            chk(resp.next_pc, exp_r.next_pc);
            chk(resp.bit_branch_target, exp_r.bit_branch_target);
            chk(resp.tested_byte_pointer, exp_r.tested_byte_pointer);
            chk(resp.carry_write, exp_r.carry_write);
            chk(resp.carry_value, exp_r.carry_value);
            chk(resp.bit_number, exp_r.bit_number);
            chk(resp.bit_select, exp_r.bit_select);
            chk(resp.branch_taken, exp_r.branch_taken);
        end
        req_valid = ($urandom % 4) != 0;
        req = 63'({$urandom, $urandom});
        // Code 7 is unused and must leave the PC where it is
        req.mode = addr_mode_t'($urandom % 8);
        // Push the offset sums to their carry boundary now and then
        if ($urandom % 8 == 0) {req.index, req.operand2} = 16'hFFFF;
        pv = req_valid;
        exp_r = model(req);
    endtask
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #60000;
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(71618));
        repeat (12) @(posedge clock);
        chk({resp_valid, resp}, 64'h0);
        @(negedge clock);
        resetn = 1;
        repeat (4000) step();
        // Mid-run reset clears the result at once, with no clock edge
        @(negedge clock);
        resetn = 0;
        req_valid = 0;
        pv = 0;
        #1;
        chk({resp_valid, resp}, 64'h0);
        repeat (2) @(negedge clock);
        resetn = 1;
        repeat (500) step();
        print_verdict();
    end
endmodule
